// ==== hdl/scps_defs.svh ====
/*
 System clock select and PLL control: register offsets, field positions, reset values.
 Assumes inclusion by bare name from the top module.
*/
`ifndef SCPS_DEFS_SVH
`define SCPS_DEFS_SVH
`define SCPS_ADDR_OSC_CTRL   4'h0
`define SCPS_ADDR_CLK_DIV    4'h1
`define SCPS_ADDR_PLL_FB     4'h2
`define SCPS_ADDR_UNLOCK     4'h3
`define SCPS_UNLOCK_KEY1     16'h0057
`define SCPS_UNLOCK_KEY2     16'h00AA
`define SCPS_CUR_LSB         12
`define SCPS_NXT_LSB         8
`define SCPS_LOCK_EN_BIT     7
`define SCPS_PLL_LOCK_BIT    5
`define SCPS_FAIL_BIT        3
`define SCPS_SEC_EN_BIT      1
`define SCPS_SWREQ_BIT       0
`define SCPS_DIV_LSB         8
`define SCPS_POST_LSB        6
`define SCPS_PRE_LSB         0
`define SCPS_CLK_DIV_RST     16'h3040
`define SCPS_PLL_FB_RST      9'h030
`define SCPS_LOCK_WAIT_US    1000
`define SCPS_CLK_MHZ         40
`define SCPS_LOCK_CYC        (`SCPS_LOCK_WAIT_US * `SCPS_CLK_MHZ)
`define SCPS_SWITCH_CYC      16
`endif

// ==== hdl/scps_pkg.sv ====
/*
 Types for the system clock select block.
 Assumes the defs header is on the include path.
*/
package scps_pkg;
    typedef enum logic [2:0] {
        SRC_FAST_RC       = 3'h0,
        SRC_FAST_RC_PLL   = 3'h1,
        SRC_PRIMARY       = 3'h2,
        SRC_PRIMARY_PLL   = 3'h3,
        SRC_SECONDARY     = 3'h4,
        SRC_LOW_POWER_RC  = 3'h5,
        SRC_FAST_RC_DIV16 = 3'h6,
        SRC_FAST_RC_DIVN  = 3'h7
    } scps_src_t;
    typedef enum logic [1:0] {
        PMODE_EXTERNAL = 2'h0,
        PMODE_STANDARD = 2'h1,
        PMODE_HIGH_SPD = 2'h2,
        PMODE_DISABLED = 2'h3
    } scps_pmode_t;
    typedef enum {SW_IDLE, SW_WAIT} scps_sw_state_t;
endpackage

// ==== hdl/scps_divider.sv ====
/*
 Programmable divider producing a one-cycle tick every div_ratio cycles.
 Assumes div_ratio of at least 1; a ratio change does not restart the count.
*/
`timescale 1ns/1ps
module scps_divider (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [9:0]  div_ratio,
    output logic             tick
);
    logic [9:0] cnt_ff;
    logic [9:0] nxt_cnt;
    logic       tick_ff;
    logic       nxt_tick;

    always_comb begin
        nxt_cnt  = cnt_ff + 10'h001;
        nxt_tick = 1'b0;
        if (cnt_ff + 10'h001 >= div_ratio) begin
            nxt_cnt  = 10'h000;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff  <= 10'h000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule

// ==== hdl/scps_sync.sv ====
/*
 Two-flop synchroniser for asynchronous status levels.
 Assumes inputs are slow levels from other clock domains.
*/
`timescale 1ns/1ps
module scps_sync #(
    parameter int W = 2
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1_ff;
    logic [W-1:0] stage2_ff;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_out = stage2_ff;
endmodule

// ==== hdl/scps_top.sv ====
/*
 System clock select and PLL control registers with source selection.
 Assumes a plain register port on ref_clk and analog PLL / oscillators outside;
 the block computes ratios, selects sources and emits tick enables for the
 divided clocks rather than gating real clocks.
*/
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "scps_defs.svh"
module scps_top #(
    parameter int LOCK_CYC = `SCPS_LOCK_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [2:0]  initial_osc_select,
    input  wire logic [1:0]  primary_osc_mode,
    input  wire logic        config_lock_mode,
    input  wire logic        switching_enabled,
    input  wire logic        pll_lock_async,
    input  wire logic        clock_fail_async,
    input  wire logic        low_power_rc_clk,
    output logic             watchdog_ref_clk,
    output logic             fail_safe_clock_monitor_ref_clk,
    output logic [2:0]       active_source,
    output logic [1:0]       active_primary_mode,
    output logic             pll_enable,
    output logic             pll_input_from_primary,
    output logic [5:0]       prescale_factor,
    output logic [9:0]       multiplier_factor,
    output logic [3:0]       postscale_factor,
    output logic [8:0]       fast_rc_divisor,
    output logic             secondary_enable,
    output logic             fast_rc_tick,
    output logic             instruction_clk_tick
);
    logic [2:0]  cur_osc_ff;
    logic [2:0]  nxt_cur_osc;
    logic [2:0]  nxt_osc_ff;
    logic [2:0]  nxt_nxt_osc;
    logic [1:0]  pmode_ff;
    logic [1:0]  nxt_pmode;
    logic        lock_en_ff;
    logic        nxt_lock_en;
    logic        fail_ff;
    logic        nxt_fail;
    logic        sec_en_ff;
    logic        nxt_sec_en;
    logic        swreq_ff;
    logic        nxt_swreq;
    logic [2:0]  rc_div_ff;
    logic [2:0]  nxt_rc_div;
    logic [1:0]  post_ff;
    logic [1:0]  nxt_post;
    logic [4:0]  pre_ff;
    logic [4:0]  nxt_pre;
    logic [4:0]  div_hi_ff;
    logic [4:0]  nxt_div_hi;
    logic [8:0]  mul_ff;
    logic [8:0]  nxt_mul;
    logic [1:0]  unlock_ff;
    logic [1:0]  nxt_unlock;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic [31:0] lock_cnt_ff;
    logic [31:0] nxt_lock_cnt;
    logic [4:0]  sw_cnt_ff;
    logic [4:0]  nxt_sw_cnt;
    scps_pkg::scps_sw_state_t sw_state_ff;
    scps_pkg::scps_sw_state_t nxt_sw_state;
    logic        pll_lock_s;
    logic        fail_s;
    logic        fail_prev_ff;
    logic        pll_locked;
    logic        cfg_locked;
    logic        wr_osc;
    logic        unlocked;
    logic        is_pll_src;
    logic [9:0]  base_ratio;
    logic [9:0]  sys_ratio;
    logic        strap_done_ff;

    scps_sync #(.W(2)) u_sync (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in ({pll_lock_async, clock_fail_async}),
        .sync_out ({pll_lock_s, fail_s})
    );

    // Low-power RC is a free-running oscillator, fanned out unbuffered
    assign watchdog_ref_clk = low_power_rc_clk;
    assign fail_safe_clock_monitor_ref_clk     = low_power_rc_clk;

    // Freeze needs both the lock-mode config bit and the software lock
    assign cfg_locked = config_lock_mode && lock_en_ff;
    assign unlocked   = (unlock_ff == 2'h2);
    assign wr_osc     = reg_wr && (reg_addr == `SCPS_ADDR_OSC_CTRL) && unlocked;
    assign is_pll_src = (cur_osc_ff == scps_pkg::SRC_FAST_RC_PLL)
                     || (cur_osc_ff == scps_pkg::SRC_PRIMARY_PLL);

    // Timer-based lock fallback covers a PLL without a lock detector
    assign pll_locked = is_pll_src && (pll_lock_s || (lock_cnt_ff >= 32'(LOCK_CYC)));

    always_comb begin
        nxt_unlock = unlock_ff;
        if (reg_wr) begin
            if (reg_addr == `SCPS_ADDR_UNLOCK && reg_wdata == `SCPS_UNLOCK_KEY1) begin
                nxt_unlock = 2'h1;
            end else if (reg_addr == `SCPS_ADDR_UNLOCK && reg_wdata == `SCPS_UNLOCK_KEY2
                         && unlock_ff == 2'h1) begin
                nxt_unlock = 2'h2;
            end else begin
                nxt_unlock = 2'h0;
            end
        end
    end

    always_comb begin
        nxt_nxt_osc = nxt_osc_ff;
        nxt_lock_en = lock_en_ff;
        nxt_sec_en  = sec_en_ff;
        nxt_fail    = fail_ff;
        nxt_swreq   = swreq_ff;
        nxt_cur_osc = cur_osc_ff;
        nxt_sw_state = sw_state_ff;
        nxt_sw_cnt  = sw_cnt_ff;
        nxt_pmode   = pmode_ff;
        if (wr_osc) begin
            if (!cfg_locked) begin
                nxt_nxt_osc = reg_wdata[`SCPS_NXT_LSB +: 3];
            end
            // Lock enable can only be set once per reset
            nxt_lock_en = lock_en_ff | reg_wdata[`SCPS_LOCK_EN_BIT];
            nxt_sec_en  = reg_wdata[`SCPS_SEC_EN_BIT];
            if (!reg_wdata[`SCPS_FAIL_BIT]) begin
                nxt_fail = 1'b0;
            end
            if (switching_enabled && !cfg_locked && reg_wdata[`SCPS_SWREQ_BIT]) begin
                nxt_swreq = 1'b1;
            end
        end
        if (fail_s && !fail_prev_ff) begin
            nxt_fail = 1'b1;
        end
        // Fixed wait stands in for oscillator start-up and settling
        unique case (sw_state_ff)
            scps_pkg::SW_IDLE: begin
                if (swreq_ff) begin
                    nxt_sw_state = scps_pkg::SW_WAIT;
                    nxt_sw_cnt   = 5'h00;
                end
            end
            scps_pkg::SW_WAIT: begin
                nxt_sw_cnt = sw_cnt_ff + 5'h01;
                if (sw_cnt_ff == 5'(`SCPS_SWITCH_CYC - 1)) begin
                    nxt_cur_osc  = nxt_osc_ff;
                    nxt_swreq    = 1'b0;
                    nxt_sw_state = scps_pkg::SW_IDLE;
                end
            end
        endcase
        if (!switching_enabled) begin
            nxt_swreq = 1'b0;
        end
        // Power-on source comes from the straps, not from software
        if (!strap_done_ff) begin
            nxt_cur_osc = initial_osc_select;
            nxt_nxt_osc = initial_osc_select;
            nxt_pmode   = primary_osc_mode;
        end
    end

    always_comb begin
        // Upper clock_div bits are kept for readback only
        nxt_div_hi = div_hi_ff;
        nxt_mul    = mul_ff;
        if (reg_wr && !cfg_locked) begin
            if (reg_addr == `SCPS_ADDR_CLK_DIV) begin
                nxt_div_hi = reg_wdata[15:11];
            end
            if (reg_addr == `SCPS_ADDR_PLL_FB) begin
                nxt_mul = reg_wdata[8:0];
            end
        end
        nxt_rc_div = rc_div_ff;
        nxt_post   = post_ff;
        nxt_pre    = pre_ff;
        if (reg_wr && !cfg_locked && reg_addr == `SCPS_ADDR_CLK_DIV) begin
            nxt_rc_div = reg_wdata[`SCPS_DIV_LSB +: 3];
            nxt_post   = reg_wdata[`SCPS_POST_LSB +: 2];
            nxt_pre    = reg_wdata[`SCPS_PRE_LSB +: 5];
        end
        nxt_lock_cnt = lock_cnt_ff;
        if (!is_pll_src || sw_state_ff == scps_pkg::SW_WAIT) begin
            nxt_lock_cnt = 32'h0;
        end else if (lock_cnt_ff < 32'(LOCK_CYC)) begin
            nxt_lock_cnt = lock_cnt_ff + 32'h1;
        end
    end

    // Registered read data stands only in the cycle after the strobe
    always_comb begin
        nxt_rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `SCPS_ADDR_OSC_CTRL: begin
                    nxt_rdata[`SCPS_CUR_LSB +: 3]  = cur_osc_ff;
                    nxt_rdata[`SCPS_NXT_LSB +: 3]  = nxt_osc_ff;
                    nxt_rdata[`SCPS_LOCK_EN_BIT]   = lock_en_ff;
                    nxt_rdata[`SCPS_PLL_LOCK_BIT]  = pll_locked;
                    nxt_rdata[`SCPS_FAIL_BIT]      = fail_ff;
                    nxt_rdata[`SCPS_SEC_EN_BIT]    = sec_en_ff;
                    nxt_rdata[`SCPS_SWREQ_BIT]     = swreq_ff;
                end
                `SCPS_ADDR_CLK_DIV: begin
                    // Bit 5 is unimplemented and stays zero
                    nxt_rdata[15:11]               = div_hi_ff;
                    nxt_rdata[`SCPS_DIV_LSB +: 3]  = rc_div_ff;
                    nxt_rdata[`SCPS_POST_LSB +: 2] = post_ff;
                    nxt_rdata[`SCPS_PRE_LSB +: 5]  = pre_ff;
                end
                `SCPS_ADDR_PLL_FB: begin
                    nxt_rdata = {7'h00, mul_ff};
                end
                default: begin
                    nxt_rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_osc_ff   <= 3'h7;
            nxt_osc_ff   <= 3'h7;
            pmode_ff     <= 2'h3;
            lock_en_ff   <= 1'b0;
            fail_ff      <= 1'b0;
            sec_en_ff    <= 1'b0;
            swreq_ff     <= 1'b0;
            rc_div_ff    <= 3'h0;
            post_ff      <= 2'h1;
            pre_ff       <= 5'h00;
            div_hi_ff    <= 5'h06;
            mul_ff       <= `SCPS_PLL_FB_RST;
            unlock_ff    <= 2'h0;
            rdata_ff     <= 16'h0000;
            lock_cnt_ff  <= 32'h0;
            sw_cnt_ff    <= 5'h00;
            sw_state_ff  <= scps_pkg::SW_IDLE;
            fail_prev_ff <= 1'b0;
        end else begin
            cur_osc_ff   <= nxt_cur_osc;
            nxt_osc_ff   <= nxt_nxt_osc;
            pmode_ff     <= nxt_pmode;
            lock_en_ff   <= nxt_lock_en;
            fail_ff      <= nxt_fail;
            sec_en_ff    <= nxt_sec_en;
            swreq_ff     <= nxt_swreq;
            rc_div_ff    <= nxt_rc_div;
            post_ff      <= nxt_post;
            pre_ff       <= nxt_pre;
            div_hi_ff    <= nxt_div_hi;
            mul_ff       <= nxt_mul;
            unlock_ff    <= nxt_unlock;
            rdata_ff     <= nxt_rdata;
            lock_cnt_ff  <= nxt_lock_cnt;
            sw_cnt_ff    <= nxt_sw_cnt;
            sw_state_ff  <= nxt_sw_state;
            fail_prev_ff <= fail_s;
        end
    end

    // Straps caught once, in the first cycle after reset release
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_done_ff <= 1'b0;
        end else begin
            strap_done_ff <= 1'b1;
        end
    end

    logic [2:0] boot_src_ff;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_src_ff <= 3'h7;
        end else if (!strap_done_ff) begin
            boot_src_ff <= initial_osc_select;
        end
    end

    // Until straps settle, or while switching is disabled, the effective source follows the strap capture
    logic [2:0] eff_src;
    assign eff_src = strap_done_ff && switching_enabled ? cur_osc_ff : boot_src_ff;

    assign active_source          = eff_src;
    assign active_primary_mode    = pmode_ff;
    assign pll_enable             = (eff_src == scps_pkg::SRC_FAST_RC_PLL)
                                 || (eff_src == scps_pkg::SRC_PRIMARY_PLL);
    assign pll_input_from_primary = (eff_src == scps_pkg::SRC_PRIMARY_PLL);
    assign prescale_factor        = {1'b0, pre_ff} + 6'h02;
    assign multiplier_factor      = {1'b0, mul_ff} + 10'h002;
    assign postscale_factor       = (post_ff == 2'h0) ? 4'h2 :
                                    (post_ff == 2'h1) ? 4'h4 : 4'h8;
    // Top code skips 128 and jumps straight to 256
    always_comb begin
        if (rc_div_ff == 3'h7) begin
            fast_rc_divisor = 9'h100;
        end else begin
            fast_rc_divisor = 9'h001 << rc_div_ff;
        end
    end
    assign secondary_enable       = sec_en_ff || (eff_src == scps_pkg::SRC_SECONDARY);
    assign reg_rdata              = rdata_ff;

    // Tick model: fast RC divider ratio, and system divide-by-two
    always_comb begin
        unique case (eff_src)
            scps_pkg::SRC_FAST_RC_DIV16: base_ratio = 10'h010;
            scps_pkg::SRC_FAST_RC_DIVN:  base_ratio = {1'b0, fast_rc_divisor};
            default:                      base_ratio = 10'h001;
        endcase
        sys_ratio = 10'h002;
    end

    scps_divider u_rc_div (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .div_ratio (base_ratio),
        .tick      (fast_rc_tick)
    );

    // PLL frequency is formed outside from the three factor outputs
    scps_divider u_cy_div (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .div_ratio (sys_ratio),
        .tick      (instruction_clk_tick)
    );
endmodule

// ==== tb/scps_top_monitor.sv ====
/*
 Port-level checker for the clock select block.
 Assumes binding to scps_top; sees only its ports.
*/
`timescale 1ns/1ps
module scps_top_monitor #(
    parameter int LOCK_CYC = 40000
) (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        low_power_rc_clk,
    input wire logic        watchdog_ref_clk,
    input wire logic        fail_safe_clock_monitor_ref_clk,
    input wire logic [2:0]  active_source,
    input wire logic        pll_enable,
    input wire logic        pll_input_from_primary,
    input wire logic [5:0]  prescale_factor,
    input wire logic [9:0]  multiplier_factor,
    input wire logic [3:0]  postscale_factor,
    input wire logic [8:0]  fast_rc_divisor,
    input wire logic        instruction_clk_tick
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wdt_ref_a: assert property (watchdog_ref_clk == low_power_rc_clk)
        else $error("watchdog reference differs from low-power clock");
    fail_safe_clock_monitor_ref_a: assert property (fail_safe_clock_monitor_ref_clk == low_power_rc_clk)
        else $error("monitor reference differs from low-power clock");
    pre_ratio_a: assert property (reg_rd && reg_addr == 4'h1 |=>
        prescale_factor == {1'b0, reg_rdata[4:0]} + 6'h02) else $error("prescale mismatch");
    post_ratio_a: assert property (reg_rd && reg_addr == 4'h1 |=>
        postscale_factor == (reg_rdata[7:6] == 2'h0 ? 4'h2 : reg_rdata[7:6] == 2'h1 ? 4'h4 : 4'h8))
        else $error("postscale mismatch");
    rc_div_a: assert property (reg_rd && reg_addr == 4'h1 |=>
        fast_rc_divisor == (reg_rdata[10:8] == 3'h7 ? 9'h100 : 9'h001 << reg_rdata[10:8]))
        else $error("rc divisor mismatch");
    mul_ratio_a: assert property (reg_rd && reg_addr == 4'h2 |=>
        multiplier_factor == {1'b0, reg_rdata[8:0]} + 10'h002 && reg_rdata[15:9] == 7'h00)
        else $error("multiplier mismatch");
    osc_unimpl_a: assert property (reg_rd && reg_addr == 4'h0 |=>
        (reg_rdata & 16'h8854) == 16'h0000) else $error("unused control bit set");
    cur_src_a: assert property (reg_rd && reg_addr == 4'h0 |=>
        reg_rdata[14:12] == $past(active_source)) else $error("current source mismatch");
    pll_path_a: assert property (pll_enable ==
        (active_source == 3'h1 || active_source == 3'h3))
        else $error("pll enable disagrees with source");
    pll_src_a: assert property (pll_enable |->
        pll_input_from_primary == (active_source == 3'h3))
        else $error("pll input path wrong");
    instr_tick_a: assert property (instruction_clk_tick |=> !instruction_clk_tick)
        else $error("instruction tick too long");
endmodule
bind scps_top scps_top_monitor #(.LOCK_CYC(LOCK_CYC)) u_mon (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .low_power_rc_clk(low_power_rc_clk),
    .watchdog_ref_clk(watchdog_ref_clk), .fail_safe_clock_monitor_ref_clk(fail_safe_clock_monitor_ref_clk),
    .active_source(active_source), .pll_enable(pll_enable),
    .pll_input_from_primary(pll_input_from_primary), .prescale_factor(prescale_factor),
    .multiplier_factor(multiplier_factor), .postscale_factor(postscale_factor),
    .fast_rc_divisor(fast_rc_divisor), .instruction_clk_tick(instruction_clk_tick)
);

// ==== tb/scps_osc_model.sv ====
/*
 Oscillator and PLL side: low-power RC clock, lock and failure levels.
 Assumes the bench commands lock hold-off and failure events.
*/
`timescale 1ns/1ps
module scps_osc_model #(
    parameter int LOW_POWER_RC_SOURCE_HALF_NS = 15259,
    parameter int LOCK_DLY     = 6
) (
    input  wire logic ref_clk,
    input  wire logic pll_enable,
    input  wire logic hold_unlock,
    input  wire logic fail_cmd,
    output logic      low_power_rc_clk,
    output logic      pll_lock_async,
    output logic      clock_fail_async
);
    int cnt = 0;
    // Free running: the low-power oscillator never stops
    initial begin
        low_power_rc_clk = 1'b0;
        forever #(LOW_POWER_RC_SOURCE_HALF_NS) low_power_rc_clk = ~low_power_rc_clk;
    end
    // Lock only after a settling delay, never while disabled
    always @(posedge ref_clk) begin
        cnt <= pll_enable ? cnt + 1 : 0;
        pll_lock_async <= pll_enable && !hold_unlock && cnt >= LOCK_DLY;
    end
    assign clock_fail_async = fail_cmd;
endmodule

// ==== tb/scps_top_tb.sv ====
/*
 Self-checking bench for the clock select block.
 Assumes the oscillator model on the far side and a 40 MHz reference.
*/
`timescale 1ns/1ps
module scps_top_tb;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [2:0]  initial_osc_select = 3'h7;
    logic [1:0]  primary_osc_mode = 2'h3;
    logic        config_lock_mode = 1'b0;
    logic        hold_unlock = 1'b0;
    logic        fail_cmd = 1'b0;
    logic        pll_lock_async, clock_fail_async, low_power_rc_clk, pll_enable, secondary_enable;
    logic [2:0]  active_source;
    logic [1:0]  active_primary_mode;
    logic [5:0]  prescale_factor;
    logic [9:0]  multiplier_factor;
    logic [3:0]  postscale_factor;
    logic [8:0]  fast_rc_divisor;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cycles = 0;
    localparam int LOCK_SIM = 20;
    scps_top #(.LOCK_CYC(LOCK_SIM)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .initial_osc_select(initial_osc_select), .primary_osc_mode(primary_osc_mode),
        .config_lock_mode(config_lock_mode), .switching_enabled(1'b1),
        .pll_lock_async(pll_lock_async), .clock_fail_async(clock_fail_async),
        .low_power_rc_clk(low_power_rc_clk), .watchdog_ref_clk(), .fail_safe_clock_monitor_ref_clk(),
        .active_source(active_source), .active_primary_mode(active_primary_mode),
        .pll_enable(pll_enable), .pll_input_from_primary(),
        .prescale_factor(prescale_factor), .multiplier_factor(multiplier_factor),
        .postscale_factor(postscale_factor), .fast_rc_divisor(fast_rc_divisor),
        .secondary_enable(secondary_enable), .fast_rc_tick(), .instruction_clk_tick()
    );
    scps_osc_model i_osc (
        .ref_clk(ref_clk), .pll_enable(pll_enable), .hold_unlock(hold_unlock),
        .fail_cmd(fail_cmd), .low_power_rc_clk(low_power_rc_clk),
        .pll_lock_async(pll_lock_async), .clock_fail_async(clock_fail_async)
    );
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard: far above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic unl_wr(input logic [15:0] d);
        wr(4'h3, 16'h0057);
        wr(4'h3, 16'h00AA);
        wr(4'h0, d);
    endtask
    task automatic do_reset(input logic [2:0] s, input logic [1:0] m);
        rst_b <= 1'b0;
        initial_osc_select <= s;
        primary_osc_mode <= m;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic wait_sw(output logic [15:0] d);
        int n;
        n = 0;
        rd(4'h0, d);
        while (d[0] !== 1'b0 && n < 30) begin
            rd(4'h0, d);
            n++;
        end
        chk(16'(d[0]), 16'h0000);
    endtask
    task automatic t_straps;
        logic [15:0] d;
        for (int k = 0; k < 8; k++) begin
            do_reset(3'(k), 2'(k % 3));
            rd(4'h0, d);
            chk(16'(d[14:12]), 16'(k));
            chk(16'(d[10:8]), 16'(k));
            chk(16'(active_source), 16'(k));
            chk(16'(active_primary_mode), 16'(k % 3));
            chk(16'(secondary_enable), 16'(k == 4));
            chk(d & 16'h008B, 16'h0000);
        end
        do_reset(3'h7, 2'h3);
        rd(4'h0, d);
        chk(16'(d[14:12]), 16'h0007);
    endtask
    task automatic t_ratios;
        logic [15:0] d, w;
        logic [15:0] mv [3] = '{16'h0000, 16'h001E, 16'hFFFF};
        int pt [4] = '{2, 4, 8, 8};
        rd(4'h1, d);
        chk(d, 16'h3040);
        rd(4'h2, d);
        chk(d, 16'h0030);
        chk(16'(multiplier_factor), 16'h0032);
        chk(16'(prescale_factor), 16'h0002);
        for (int k = 0; k < 8; k++) begin
            w = {5'h00, 3'(k), 2'(k), 1'b0, 5'(k * 4 + 3)};
            wr(4'h1, w);
            rd(4'h1, d);
            chk(d, w);
            chk(16'(fast_rc_divisor), 16'(k == 7 ? 256 : 1 << k));
            chk(16'(prescale_factor), 16'(k * 4 + 5));
            chk(16'(postscale_factor), 16'(pt[k % 4]));
        end
        for (int k = 0; k < 3; k++) begin
            wr(4'h2, mv[k]);
            rd(4'h2, d);
            chk(d, mv[k] & 16'h01FF);
            chk(16'(multiplier_factor), 16'(mv[k][8:0]) + 16'h0002);
        end
    endtask
    task automatic t_unlock;
        logic [15:0] d;
        wr(4'h0, 16'h0200);
        wr(4'h3, 16'h0057);
        wr(4'h1, 16'h3040);
        wr(4'h3, 16'h00AA);
        wr(4'h0, 16'h0200);
        rd(4'h0, d);
        chk(16'(d[10:8]), 16'h0007);
        unl_wr(16'h0200);
        rd(4'h0, d);
        chk(16'(d[10:8]), 16'h0002);
    endtask
    task automatic t_switch;
        logic [15:0] d;
        hold_unlock <= 1'b1;
        unl_wr(16'h0101);
        rd(4'h0, d);
        chk(16'(d[0]), 16'h0001);
        wait_sw(d);
        chk(16'(d[14:12]), 16'h0001);
        chk(16'(d[5]), 16'h0000);
        repeat (LOCK_SIM + 5) @(posedge ref_clk);
        rd(4'h0, d);
        chk(16'(d[5]), 16'h0001);
        hold_unlock <= 1'b0;
        unl_wr(16'h0501);
        wait_sw(d);
        chk(16'(d[14:12]), 16'h0005);
        chk(16'(d[5]), 16'h0000);
    endtask
    task automatic t_fail;
        logic [15:0] d;
        fail_cmd <= 1'b1;
        repeat (4) @(posedge ref_clk);
        fail_cmd <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(4'h0, d);
        rd(4'h0, d);
        chk(16'(d[3]), 16'h0001);
        unl_wr(d & 16'h0700);
        rd(4'h0, d);
        chk(16'(d[3]), 16'h0000);
    endtask
    task automatic t_lock;
        logic [15:0] d;
        unl_wr(16'h0580);
        wr(4'h1, 16'h0005);
        config_lock_mode <= 1'b1;
        wr(4'h1, 16'h0001);
        unl_wr(16'h0480);
        rd(4'h1, d);
        chk(d, 16'h0005);
        rd(4'h0, d);
        chk(16'(d[10:7]), 16'h000B);
        chk(16'(prescale_factor), 16'h0007);
        config_lock_mode <= 1'b0;
        wr(4'h1, 16'h0002);
        rd(4'h1, d);
        chk(d, 16'h0002);
    endtask
    initial begin
        do_reset(3'h7, 2'h3);
        t_straps();
        t_ratios();
        t_unlock();
        t_switch();
        t_fail();
        t_lock();
        final_report();
    end
endmodule
